// ### wdfl_pkg.sv
// Package for the dual watchdog, fault log and configuration lock block.
// Assumes a 10 MHz clock and an outside serial engine giving byte requests.
package wdfl_pkg;

    // Register offsets
    localparam logic [7:0] WD1_INSEL_ADDR    = 8'h3C;
    localparam logic [7:0] WD1_TSEL_ADDR     = 8'h3D;
    localparam logic [7:0] WD2_INSEL_ADDR    = 8'h3E;
    localparam logic [7:0] WD2_TSEL_ADDR     = 8'h3F;
    localparam logic [7:0] WR_BLOCK_ADDR     = 8'h43;
    localparam logic [7:0] CFG_LOCK_ADDR     = 8'h45;
    localparam logic [7:0] FLT_PRIMARY_ADDR  = 8'h60;
    localparam logic [7:0] FLT_SECOND_ADDR   = 8'h61;
    localparam logic [7:0] FLT_INPUT_ADDR    = 8'h62;

    // Input-selection register fields
    localparam int INSEL_GPI_LSB  = 0;
    localparam int INSEL_PO_LSB   = 2;
    localparam int INSEL_DEP_LSB  = 5;
    localparam int INSEL_INIT_BIT = 7;
    // Timeout-select register fields
    localparam int TSEL_NORM_LSB  = 0;
    localparam int TSEL_INIT_LSB  = 3;
    localparam int TSEL_EN_BIT    = 6;
    // Lock register field
    localparam int LOCK_BIT       = 0;
    // Third fault register fields
    localparam int FLT_WD_LSB     = 0;
    localparam int FLT_GPI_LSB    = 2;
    localparam int FLT_MR_BIT     = 6;

    // Clear-dependency codes
    localparam logic [1:0] DEP_PO_ONLY  = 2'h1;
    localparam logic [1:0] DEP_GPI_ONLY = 2'h2;

    // Reset values (volatile copy is empty until the download fills it)
    localparam logic [7:0] CFG_RESET_VAL = 8'h00;
    localparam logic [7:0] FLT_RESET_VAL = 8'h00;
    localparam logic [7:0] INVALID_READ  = 8'h00;

    // Timing: shortest watchdog period is 6.25 ms, each code step is x4
    localparam int CLK_PERIOD_NS  = 100;
    localparam int WD_BASE_NS     = 6250000;
    localparam int WD_BASE_CYCLES = WD_BASE_NS / CLK_PERIOD_NS;

    // Configuration bytes copied from nonvolatile store after power-up
    localparam int          DL_COUNT = 6;
    localparam logic [2:0]  DL_LAST  = 3'h5;

    typedef struct packed {
        logic       req;   // one-cycle request strobe
        logic       we;    // 1 = write, 0 = read
        logic [7:0] addr;  // register offset
        logic [7:0] wdata; // write byte
    } wdfl_req_type;

    typedef struct packed {
        logic       ack;   // one-cycle accept pulse
        logic       nack;  // one-cycle refuse pulse
        logic [7:0] rdata; // read byte, valid with ack
    } wdfl_rsp_type;

    typedef enum logic [1:0] {
        DL_WAIT    = 2'b00,
        DL_FETCH   = 2'b01,
        DL_CAPTURE = 2'b10,
        DL_READY   = 2'b11
    } wdfl_dl_type;

endpackage : wdfl_pkg

// ### wdfl_top.sv
// Dual watchdog timers, sticky fault log, configuration lock, user-memory
// write block and power-up configuration download.
// Assumes: rst is power-up reset; async pins are synchronised, all else is on clk.
//
// Notes on behaviour
// R01: Initial period (field 5:3) applies after power-up, reset event or enabling.
// R02: After the first interval is served, the normal period is used.
// R03: Missing clear within a normal interval declares a watchdog fault.
// R04: Missing clear within the initial interval also declares a fault.
// R05: Period codes 0..7 give 6.25 ms times four per step up to 102.4 s.
// R06: Timeout register bit 6 enables the watchdog; bit 7 unused.
// R07: Initial period is enabled per watchdog via its input-selection register.
// R08: Processor must toggle the watchdog input within the timeout period.
// R09: Fault registers are read-only and cleared by power loss.
// R10: First fault read after power-up is invalid; host discards it.
// R11: Manual reset assertion sets fault bit 6 of the third register.
// R12: Reading a fault register clears all fault flags.
// R13: First fault register flags primary undervoltage per detector, bits 5:0.
// R14: Second fault register flags secondary threshold crossings, bits 5:0.
// R15: Third register: watchdogs at bits 1:0, general inputs at bits 5:2.
// R16: Watchdog fault on a general input sets both input and watchdog flags.
// R17: Lock bit blocks writes to all registers except the lock register.
// R18: Write-block mask bit blocks user-memory writes while its output asserts.
// R19: Config is copied in after supply lockout passes; outputs wait for it.
// R20: Serial access before the download finishes is refused with a nack.
// R21: Input register selects general input, output and clear dependency.
// R22: Input register bit 7 enables the initial period only.
// R23: Watchdog fault asserts the outputs configured to depend on it.
// R24: Writes act within 5 us; new stored config needs reboot or power cycle.
// R25: Any edge on the selected source restarts the count and ends initial.
// R26: Fault flags stay set until a register read clears them.
`timescale 1ns/10ps

module wdfl_top #(
    parameter int unsigned WD_BASE_CYC = wdfl_pkg::WD_BASE_CYCLES  // cycles in 6.25 ms
) (
    input  wire logic                  clk,              // 10 MHz core clock
    input  wire logic                  rst,              // power-up reset, sync, high
    input  wire wdfl_pkg::wdfl_req_type reg_req,         // register request
    output wdfl_pkg::wdfl_rsp_type     reg_rsp,          // register answer
    input  wire logic [3:0]            general_input_n,  // general inputs, active high
    input  wire logic                  manual_reset_in,  // manual reset, active high
    input  wire logic                  supply_lockout_ok,// supply above lockout threshold
    input  wire logic [7:0]            po_state,         // asserted programmable outputs
    input  wire logic                  reset_event,      // system reset event pulse
    input  wire logic                  reboot_req,       // software reboot pulse
    input  wire logic [5:0]            primary_uv,       // primary undervoltage levels
    input  wire logic [5:0]            secondary_trip,   // secondary threshold levels
    input  wire logic [7:0]            wd1_po_dep,       // outputs depending on watchdog 1
    input  wire logic [7:0]            wd2_po_dep,       // outputs depending on watchdog 2
    output logic [7:0]                 nv_rd_addr,       // nonvolatile read address
    output logic                       nv_rd_en,         // nonvolatile read strobe
    input  wire logic [7:0]            nv_rd_data,       // data one cycle after strobe
    output logic                       config_ready,     // download complete
    output logic [1:0]                 wd_timeout,       // watchdog expired levels
    output logic [7:0]                 wd_po_assert,     // outputs forced by watchdogs
    output logic                       user_mem_wr_block // user-memory write blocked
);

    // Synchronisers
    logic [3:0] gpi_m_q, gpi_s_q, gpi_p_q;
    logic       mr_m_q, mr_s_q;
    logic       supply_lockout_threshold_m_q, supply_lockout_threshold_s_q;
    logic [7:0] po_p_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            gpi_m_q  <= 4'h0;
            gpi_s_q  <= 4'h0;
            gpi_p_q  <= 4'h0;
            mr_m_q   <= 1'b0;
            mr_s_q   <= 1'b0;
            supply_lockout_threshold_m_q <= 1'b0;
            supply_lockout_threshold_s_q <= 1'b0;
            po_p_q   <= 8'h00;
        end
        else
        begin
            gpi_m_q  <= general_input_n;
            gpi_s_q  <= gpi_m_q;
            gpi_p_q  <= gpi_s_q;
            mr_m_q   <= manual_reset_in;
            mr_s_q   <= mr_m_q;
            supply_lockout_threshold_m_q <= supply_lockout_ok;
            supply_lockout_threshold_s_q <= supply_lockout_threshold_m_q;
            po_p_q   <= po_state;
        end
    end

    // Configuration registers
    logic [7:0] insel_q [2];
    logic [7:0] tsel_q  [2];
    logic [7:0] wr_block_q;
    logic [7:0] lock_q;

    // Download sequencer
    wdfl_pkg::wdfl_dl_type dl_q;
    logic [2:0]            dl_idx_q;
    logic [7:0]            dl_addr;
    logic                  dl_load_q;

    always_comb
    begin
        unique case (dl_idx_q)
            3'h0:    dl_addr = wdfl_pkg::WD1_INSEL_ADDR;
            3'h1:    dl_addr = wdfl_pkg::WD1_TSEL_ADDR;
            3'h2:    dl_addr = wdfl_pkg::WD2_INSEL_ADDR;
            3'h3:    dl_addr = wdfl_pkg::WD2_TSEL_ADDR;
            3'h4:    dl_addr = wdfl_pkg::WR_BLOCK_ADDR;
            default: dl_addr = wdfl_pkg::CFG_LOCK_ADDR;
        endcase
    end

    // A reboot re-runs the copy so changed stored bytes take hold
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dl_q       <= wdfl_pkg::DL_WAIT;
            dl_idx_q   <= 3'h0;
            nv_rd_addr <= 8'h00;
            nv_rd_en   <= 1'b0;
            dl_load_q  <= 1'b0;
        end
        else
        begin
            nv_rd_en <= 1'b0;
            // Store answers a cycle after the strobe
            dl_load_q <= nv_rd_en;
            unique case (dl_q)
                wdfl_pkg::DL_WAIT:
                begin
                    dl_idx_q <= 3'h0;
                    if (supply_lockout_threshold_s_q)                                    // [R19]
                        dl_q <= wdfl_pkg::DL_FETCH;
                end
                wdfl_pkg::DL_FETCH:
                begin
                    nv_rd_addr <= dl_addr;
                    nv_rd_en   <= 1'b1;
                    dl_q       <= wdfl_pkg::DL_CAPTURE;
                end
                wdfl_pkg::DL_CAPTURE:
                begin
                    if (dl_idx_q == wdfl_pkg::DL_LAST)
                        dl_q <= wdfl_pkg::DL_READY;
                    else
                    begin
                        dl_idx_q <= dl_idx_q + 3'h1;
                        dl_q     <= wdfl_pkg::DL_FETCH;
                    end
                end
                wdfl_pkg::DL_READY:
                begin
                    if (reboot_req)                                  // [R24]
                        dl_q <= wdfl_pkg::DL_WAIT;
                end
            endcase
        end
    end

    logic dl_done;
    assign dl_done = (dl_q == wdfl_pkg::DL_READY);

    always_ff @(posedge clk)
    begin
        if (rst)
            config_ready <= 1'b0;
        else
            config_ready <= dl_done;
    end

    // Download fills the copy; host writes obey the lock
    logic       host_wr;
    logic       cfg_wr;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       locked;

    assign locked  = lock_q[wdfl_pkg::LOCK_BIT];
    assign host_wr = reg_req.req && reg_req.we && config_ready;              // [R20]
    assign cfg_wr  = dl_load_q || (host_wr && (!locked || reg_req.addr == wdfl_pkg::CFG_LOCK_ADDR)); // [R17]
    assign wr_addr = dl_load_q ? nv_rd_addr : reg_req.addr;
    assign wr_data = dl_load_q ? nv_rd_data : reg_req.wdata;

    // Writes land on the next edge, well inside 5 us
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            insel_q[0] <= wdfl_pkg::CFG_RESET_VAL;
            insel_q[1] <= wdfl_pkg::CFG_RESET_VAL;
            tsel_q[0]  <= wdfl_pkg::CFG_RESET_VAL;
            tsel_q[1]  <= wdfl_pkg::CFG_RESET_VAL;
            wr_block_q <= wdfl_pkg::CFG_RESET_VAL;
            lock_q     <= wdfl_pkg::CFG_RESET_VAL;
        end
        else if (cfg_wr)                                             // [R24]
        begin
            unique case (wr_addr)
                wdfl_pkg::WD1_INSEL_ADDR: insel_q[0] <= wr_data;
                wdfl_pkg::WD1_TSEL_ADDR:  tsel_q[0]  <= wr_data;
                wdfl_pkg::WD2_INSEL_ADDR: insel_q[1] <= wr_data;
                wdfl_pkg::WD2_TSEL_ADDR:  tsel_q[1]  <= wr_data;
                wdfl_pkg::WR_BLOCK_ADDR:  wr_block_q <= wr_data;
                wdfl_pkg::CFG_LOCK_ADDR:  lock_q     <= wr_data;
                default:                  ;
            endcase
        end
    end

    // Watchdogs
    logic [1:0] wd_fault;
    logic [1:0] wd_timeout_d;

    for (genvar w = 0; w < 2; w++)
    begin : g_wd
        logic [31:0] cnt_q;
        logic        init_q;
        logic        en_p_q;
        logic [1:0]  gsel;
        logic [2:0]  psel;
        logic [1:0]  dep;
        logic        en;
        logic        init_en;
        logic [2:0]  code;
        logic [31:0] limit;
        logic        gpi_edge;
        logic        po_edge;
        logic        clr;
        logic        expire;

        assign gsel    = insel_q[w][wdfl_pkg::INSEL_GPI_LSB +: 2];           // [R21]
        assign psel    = insel_q[w][wdfl_pkg::INSEL_PO_LSB +: 3];
        assign dep     = insel_q[w][wdfl_pkg::INSEL_DEP_LSB +: 2];
        assign init_en = insel_q[w][wdfl_pkg::INSEL_INIT_BIT];               // [R07] [R22]
        assign en      = tsel_q[w][wdfl_pkg::TSEL_EN_BIT] && dl_done;        // [R06]
        assign code    = init_q ? tsel_q[w][wdfl_pkg::TSEL_INIT_LSB +: 3]   // [R01]
                                : tsel_q[w][wdfl_pkg::TSEL_NORM_LSB +: 3];   // [R02]
        assign limit   = 32'(WD_BASE_CYC) << {code, 1'b0};                   // [R05]

        // Any edge counts as a clear, so either pulse polarity works
        assign gpi_edge = gpi_s_q[gsel] ^ gpi_p_q[gsel];                     // [R25]
        assign po_edge  = po_state[psel] ^ po_p_q[psel];
        always_comb
        begin
            if (dep == wdfl_pkg::DEP_PO_ONLY)
                clr = po_edge;
            else if (dep == wdfl_pkg::DEP_GPI_ONLY)
                clr = gpi_edge;
            else
                clr = po_edge || gpi_edge;
        end
        assign expire = en && !clr && (cnt_q == limit - 32'h1);              // [R03] [R04] [R08]
        assign wd_fault[w] = expire;

        always_ff @(posedge clk)
        begin
            if (rst)
            begin
                cnt_q           <= 32'h0;
                init_q          <= 1'b1;
                en_p_q          <= 1'b0;
                wd_timeout_d[w] <= 1'b0;
            end
            else
            begin
                en_p_q <= en;
                if (!en || reset_event || (en && !en_p_q))                   // [R01]
                begin
                    cnt_q  <= 32'h0;
                    init_q <= init_en;
                    if (!en)
                        wd_timeout_d[w] <= 1'b0;
                end
                else if (clr)                                                // [R25]
                begin
                    cnt_q           <= 32'h0;
                    init_q          <= 1'b0;                                 // [R02]
                    wd_timeout_d[w] <= 1'b0;
                end
                else if (expire)
                begin
                    // Expiry resets the processor, so initial again
                    cnt_q           <= 32'h0;
                    init_q          <= init_en;
                    wd_timeout_d[w] <= 1'b1;
                end
                else
                    cnt_q <= cnt_q + 32'h1;
            end
        end
    end

    // General inputs owned by an enabled watchdog in input-clear mode
    logic [3:0] gpi_is_wd;
    logic [3:0] gpi_wd_fault;
    always_comb
    begin
        gpi_is_wd    = 4'h0;
        gpi_wd_fault = 4'h0;
        for (int w = 0; w < 2; w++)
        begin
            if (tsel_q[w][wdfl_pkg::TSEL_EN_BIT] &&
                insel_q[w][wdfl_pkg::INSEL_DEP_LSB +: 2] != wdfl_pkg::DEP_PO_ONLY)
            begin
                gpi_is_wd[insel_q[w][wdfl_pkg::INSEL_GPI_LSB +: 2]]    = 1'b1;
                if (wd_fault[w])
                    gpi_wd_fault[insel_q[w][wdfl_pkg::INSEL_GPI_LSB +: 2]] = 1'b1; // [R16]
            end
        end
    end

    // Outputs wait for a valid configuration
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wd_timeout        <= 2'h0;
            wd_po_assert      <= 8'h00;
            user_mem_wr_block <= 1'b0;
        end
        else
        begin
            wd_timeout        <= wd_timeout_d & {2{dl_done}};                // [R19]
            wd_po_assert      <= dl_done ? ((wd1_po_dep & {8{wd_timeout_d[0]}}) |
                                            (wd2_po_dep & {8{wd_timeout_d[1]}})) : 8'h00; // [R23]
            user_mem_wr_block <= dl_done && |(wr_block_q & po_state);        // [R18]
        end
    end

    // Fault log
    logic [7:0] flt_q [3];
    logic [7:0] flt_set [3];
    logic       first_read_q;
    logic       flt_rd;
    logic       flt_clr;

    assign flt_rd  = reg_req.req && !reg_req.we && config_ready &&
                     (reg_req.addr == wdfl_pkg::FLT_PRIMARY_ADDR ||
                      reg_req.addr == wdfl_pkg::FLT_SECOND_ADDR ||
                      reg_req.addr == wdfl_pkg::FLT_INPUT_ADDR);
    // The discarded first read keeps the flags
    assign flt_clr = flt_rd && !first_read_q;                                // [R12]

    assign flt_set[0] = {2'h0, primary_uv};                                  // [R13]
    assign flt_set[1] = {2'h0, secondary_trip};                              // [R14]
    assign flt_set[2] = {1'b0, mr_s_q,                                       // [R11]
                         (gpi_s_q & ~gpi_is_wd) | gpi_wd_fault,              // [R15] [R16]
                         wd_fault};

    // Set beats clear so no event slips past a read
    for (genvar f = 0; f < 3; f++)
    begin : g_flt
        always_ff @(posedge clk)
        begin
            if (rst)                                                         // [R09]
                flt_q[f] <= wdfl_pkg::FLT_RESET_VAL;
            else
                flt_q[f] <= (flt_q[f] & {8{!flt_clr}}) | flt_set[f];         // [R26]
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            first_read_q <= 1'b1;
        else if (flt_rd)
            first_read_q <= 1'b0;
    end

    // Read mux and answer
    logic [7:0] rdata;
    always_comb
    begin
        unique case (reg_req.addr)
            wdfl_pkg::WD1_INSEL_ADDR:   rdata = insel_q[0];
            wdfl_pkg::WD1_TSEL_ADDR:    rdata = tsel_q[0];
            wdfl_pkg::WD2_INSEL_ADDR:   rdata = insel_q[1];
            wdfl_pkg::WD2_TSEL_ADDR:    rdata = tsel_q[1];
            wdfl_pkg::WR_BLOCK_ADDR:    rdata = wr_block_q;
            wdfl_pkg::CFG_LOCK_ADDR:    rdata = lock_q;
            wdfl_pkg::FLT_PRIMARY_ADDR: rdata = flt_q[0];
            wdfl_pkg::FLT_SECOND_ADDR:  rdata = flt_q[1];
            wdfl_pkg::FLT_INPUT_ADDR:   rdata = flt_q[2];
            default:                    rdata = 8'h00;
        endcase
        if (flt_rd && first_read_q)
            rdata = wdfl_pkg::INVALID_READ;                                  // [R10]
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            reg_rsp <= '0;
        else
        begin
            reg_rsp.ack   <= reg_req.req && config_ready;
            reg_rsp.nack  <= reg_req.req && !config_ready;                   // [R20]
            reg_rsp.rdata <= (reg_req.req && !reg_req.we && config_ready) ? rdata : 8'h00;
        end
    end

endmodule : wdfl_top

// ### wdfl_properties.sv
// Port-level assertions for wdfl_top, bound to every instance.
// Assumes reboot_req stays low, so the download runs once per reset.
`timescale 1ns/10ps
module wdfl_properties #(
    parameter int unsigned WD_BASE_CYC = 4 // cycles in the shortest period
) (
    input wire logic                   clk,              // core clock
    input wire logic                   rst,              // sync reset
    input wire wdfl_pkg::wdfl_req_type reg_req,          // request
    input wire wdfl_pkg::wdfl_rsp_type reg_rsp,          // answer
    input wire logic [7:0]             po_state,         // output levels
    input wire logic [7:0]             wd1_po_dep,       // watchdog 1 outputs
    input wire logic                   nv_rd_en,         // store strobe
    input wire logic                   config_ready,     // download done
    input wire logic [1:0]             wd_timeout,       // expired watchdogs
    input wire logic [7:0]             wd_po_assert,     // forced outputs
    input wire logic                   user_mem_wr_block // write block
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_taken;
        reg_req.req;
    endsequence
    sequence s_answer;
        ##1 (reg_rsp.ack ^ reg_rsp.nack);
    endsequence
    property p_answer;
        s_taken |-> s_answer;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_refuse;
        s_taken and !config_ready |=> reg_rsp.nack;
    endproperty
    a_refuse: assert property (p_refuse) else $error("not refused");
    property p_accept;
        reg_req.req && config_ready |=> reg_rsp.ack;
    endproperty
    a_accept: assert property (p_accept) else $error("not accepted");
    property p_rdata;
        !reg_rsp.ack |-> reg_rsp.rdata == 8'h00;
    endproperty
    a_rdata: assert property (p_rdata) else $error("stray read data");
    property p_outputs_wait;
        !config_ready |-> wd_timeout == 2'b00 && wd_po_assert == 8'h00;
    endproperty
    a_outputs_wait: assert property (p_outputs_wait) else $error("early outputs");
    property p_nv;
        nv_rd_en |-> !config_ready ##1 !nv_rd_en;
    endproperty
    a_nv: assert property (p_nv) else $error("bad strobe");
    property p_dep;
        wd_timeout[0] && $past(wd_timeout[0]) && $stable(wd1_po_dep) |-> (wd_po_assert & wd1_po_dep) == wd1_po_dep;
    endproperty
    a_dep: assert property (p_dep) else $error("outputs not forced");
    property p_block;
        user_mem_wr_block |-> $past(|po_state);
    endproperty
    a_block: assert property (p_block) else $error("stray write block");
endmodule : wdfl_properties
bind wdfl_top wdfl_properties #(.WD_BASE_CYC(WD_BASE_CYC)) i_wdfl_properties (.clk, .rst, .reg_req, .reg_rsp,
    .po_state, .wd1_po_dep, .nv_rd_en, .config_ready, .wd_timeout, .wd_po_assert, .user_mem_wr_block);

// ### wdfl_partner.sv
// Nonvolatile store and the watchdog-pulsing processor seen by wdfl_top.
// Bytes answer one cycle after the strobe.
`timescale 1ns/10ps
module wdfl_partner (
    input  wire logic        clk,        // core clock
    input  wire logic [47:0] image,      // bytes for 3C,3D,3E,3F,43,45
    input  wire logic [7:0]  nv_rd_addr, // store address
    input  wire logic        nv_rd_en,   // store strobe
    output logic      [7:0]  nv_rd_data, // store byte
    input  wire logic        pulse_on,   // processor running
    output logic             wd_pulse    // watchdog clear line
);
    logic [7:0] data_q  = 8'h5A;
    logic       pulse_q = 1'b0;
    logic       half_q  = 1'b0;
    assign nv_rd_data = data_q;
    assign wd_pulse   = pulse_q;
    // Off-strobe the byte flips so stale data never looks valid
    always_ff @(posedge clk)
    begin
        case (nv_rd_en ? nv_rd_addr : 8'h00)
            8'h3C:   data_q <= image[47:40];
            8'h3D:   data_q <= image[39:32];
            8'h3E:   data_q <= image[31:24];
            8'h3F:   data_q <= image[23:16];
            8'h43:   data_q <= image[15:8];
            8'h45:   data_q <= image[7:0];
            default: data_q <= ~data_q;
        endcase
    end
    always_ff @(posedge clk)
    begin
        half_q <= ~half_q;
        if (pulse_on && half_q)
            pulse_q <= ~pulse_q;
    end
endmodule : wdfl_partner

// ### tb.sv
// Self-checking bench for wdfl_top.
// Assumes package, design, partner and checker are compiled first.
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
$display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
    logic                   clk = 1'b0, rst = 1'b1, mr = 1'b0, lock_ok = 1'b0, pon = 1'b0;
    logic                   pulse, nv_en, ready, blk;
    wdfl_pkg::wdfl_req_type req = '0;
    wdfl_pkg::wdfl_rsp_type rsp;
    logic [3:1]             gpi_hi = 3'h0;
    logic [7:0]             po = 8'h00, dep1 = 8'h00, nv_addr, nv_data, po_asrt, v;
    logic [5:0]             uv = 6'h00, sec = 6'h00;
    logic [1:0]             wdt;
    logic [47:0]            img = '0;
    logic [63:0]            r;
    int                     num_errors = 0, checked = 0;
    always #50 clk = ~clk;
    wdfl_top #(.WD_BASE_CYC(4)) i_wdfl_top (.clk(clk), .rst(rst), .reg_req(req), .reg_rsp(rsp),
        .general_input_n({gpi_hi, pulse}), .manual_reset_in(mr), .supply_lockout_ok(lock_ok), .po_state(po),
        .reset_event(1'b0), .reboot_req(1'b0), .primary_uv(uv), .secondary_trip(sec), .wd1_po_dep(dep1),
        .wd2_po_dep(dep1), .nv_rd_addr(nv_addr), .nv_rd_en(nv_en), .nv_rd_data(nv_data), .config_ready(ready),
        .wd_timeout(wdt), .wd_po_assert(po_asrt), .user_mem_wr_block(blk));
    wdfl_partner i_wdfl_partner (.clk(clk), .image(img), .nv_rd_addr(nv_addr), .nv_rd_en(nv_en),
        .nv_rd_data(nv_data), .pulse_on(pon), .wd_pulse(pulse));
    task automatic finish_test;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test
    task automatic acc(input logic we, input logic [7:0] a, d, output logic [9:0] res);
        req <= '{1'b1, we, a, d};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        res = {rsp.ack, rsp.nack, rsp.rdata};
        @(posedge clk);
    endtask : acc
    task automatic wr(input logic [7:0] a, d);
        logic [9:0] res;
        acc(1'b1, a, d, res);
        `CHK(res[9:8], 2'b10)
    endtask : wr
    task automatic rd(input logic [7:0] a, e);
        logic [9:0] res;
        acc(1'b0, a, 8'h00, res);
        `CHK(res, {2'b10, e})
    endtask : rd
    // Cycles until watchdog 1 expires; the window tells periods apart
    task automatic wait_to(input int lo, hi);
        int n;
        n = 0;
        while (wdt[0] !== 1'b1 && n <= hi)
        begin
            @(negedge clk);
            n++;
        end
        `CHK(n >= lo && n <= hi, 1'b1)
        if (n > hi)
            finish_test();
    endtask : wait_to
    initial
    begin
        logic [9:0] res;
        logic [7:0] ad [6];
        void'($urandom(32'hEE90D24C));
        ad = '{8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h43, 8'h45};
        r = {$urandom, $urandom};
        img <= {r[47:42], 2'h0, r[39:32] & 8'hBF, r[31:26], 2'h0, r[23:16] & 8'hBF, r[15:8], 8'h00};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        acc(1'b0, 8'h60, 8'h00, res);
        `CHK(res[9:8], 2'b01)
        lock_ok <= 1'b1;
        for (int i = 0; i < 200 && ready !== 1'b1; i++)
            @(posedge clk);
        if (ready !== 1'b1)
        begin
            num_errors++;
            finish_test();
        end
        foreach (ad[i])
            rd(ad[i], img[47 - 8 * i -: 8]);
        acc(1'b0, 8'h60, 8'h00, res);
        `CHK(res, 10'h200)
        $display("test download done");
        for (int k = 0; k < 3; k++)
        begin
            r = {$urandom, $urandom};
            uv <= r[5:0];
            sec <= r[13:8];
            gpi_hi <= r[18:16];
            mr <= 1'b1;
            repeat (4) @(posedge clk);
            uv <= 6'h00;
            sec <= 6'h00;
            gpi_hi <= 3'h0;
            mr <= 1'b0;
            repeat (4) @(posedge clk);
            v = (k == 0) ? {2'h0, r[5:0]} : (k == 1) ? {2'h0, r[13:8]} : {2'h1, r[18:16], 3'h0};
            rd(8'(8'h60 + k), v);
            rd(8'(8'h60 + (k + 1) % 3), 8'h00);
        end
        $display("test fault log done");
        v = r[31:24];
        wr(8'h45, 8'h01);
        wr(8'h43, ~v);
        rd(8'h43, img[15:8]);
        rd(8'h45, 8'h01);
        wr(8'h45, 8'h00);
        wr(8'h43, v);
        rd(8'h43, v);
        wr(8'h62, 8'hFF);
        rd(8'h62, 8'h00);
        wr(8'h50, v);
        rd(8'h50, 8'h00);
        for (int i = 0; i < 10; i++)
        begin
            po <= (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            repeat (2) @(posedge clk);
            @(negedge clk);
            `CHK(blk, |(v & po))
            @(posedge clk);
        end
        po <= 8'h00;
        $display("test lock and write block done");
        dep1 <= 8'($urandom) | 8'h01;
        wr(8'h3C, 8'h80);
        wr(8'h3D, 8'h48);
        wait_to(12, 20);
        @(posedge clk);
        @(negedge clk);
        `CHK(po_asrt & dep1, dep1)
        pon <= 1'b1;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 30; i++)
        begin
            @(negedge clk);
            `CHK(wdt[0], 1'b0)
        end
        pon <= 1'b0;
        wait_to(2, 12);
        rd(8'h62, 8'h05);
        wr(8'h3C, 8'h00);
        wr(8'h3D, 8'h00);
        wr(8'h3D, 8'h48);
        wait_to(0, 8);
        $display("test watchdog done");
        finish_test();
    end
endmodule : tb
